// File: hdl/frt_pkg.sv
/*
  Shared constants, types and helpers of the free-running capture/compare timer.
  Assumes a single 100 MHz clock, a synchronous active-low reset and an AHB-Lite register bus.
*/
package frt_pkg;

  // Counter geometry
  localparam int          CNT_W     = 16;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO  = 16'h0000;

  // Register map, byte addresses
  localparam int          ADDR_W    = 8;
  localparam logic [7:0]  ADDR_CTRL = 8'h00;  // timer_control_reg_0
  localparam logic [7:0]  ADDR_OPT  = 8'h04;  // timer_option_reg
  localparam logic [7:0]  ADDR_CCR0 = 8'h08;  // capcomp_reg_0
  localparam logic [7:0]  ADDR_CCR1 = 8'h0C;  // capcomp_reg_1
  localparam logic [7:0]  ADDR_CNT  = 8'h10;  // counter_read_buffer
  localparam logic [7:0]  ADDR_EDGE = 8'h14;  // capture edge selection
  localparam logic [7:0]  ADDR_STAT = 8'h18;  // timer output levels

  // Field positions
  localparam int CTRL_CE_BIT   = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int MODE_W        = 3;
  localparam int OPT_OVF_BIT   = 0;
  localparam int OPT_CCS_LSB   = 4;
  localparam int NCH           = 2;
  localparam int EDGE_W        = 2;
  localparam int EDGE_LSB      = 0;
  localparam int STAT_OUT_LSB  = 0;

  // Reset values
  localparam logic [2:0]  MODE_RST  = 3'h0;
  localparam logic [1:0]  CCS_RST   = 2'h0;
  localparam logic [3:0]  EDGE_RST  = 4'h0;

  // Mode encodings
  localparam logic [2:0]  MODE_PWM  = 3'h4;
  localparam logic [2:0]  MODE_FREE = 3'h5;

  // Bus constants
  localparam int          HTRANS_ACT_BIT = 1;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;
  localparam logic        HRESP_OKAY     = 1'h0;

  typedef enum logic [1:0] {
    FRT_STOP  = 2'b00,
    FRT_ARMED = 2'b01,
    FRT_RUN   = 2'b10
  } frt_state_t;

  typedef enum logic [1:0] {
    FRT_EDGE_NONE = 2'b00,
    FRT_EDGE_RISE = 2'b01,
    FRT_EDGE_FALL = 2'b10,
    FRT_EDGE_BOTH = 2'b11
  } frt_edge_t;

  // Register address match
  function automatic logic frt_hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction : frt_hit

endpackage : frt_pkg

// File: hdl/frt_if.sv
/*
  Internal carriers: register port between bus slave and core, and the per-channel link.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface frt_reg_if;
  logic        wr;
  logic [7:0]  waddr;
  logic [31:0] wdata;
  logic        rd;
  logic [7:0]  raddr;
  logic [31:0] rdata;
  modport slave (output wr, output waddr, output wdata, output rd, output raddr, input rdata);
  modport core  (input wr, input waddr, input wdata, input rd, input raddr, output rdata);
endinterface : frt_reg_if

interface frt_chan_if;
  logic [15:0] count;
  logic        tick;
  logic        running;
  logic        free_mode;
  logic        pwm_mode;
  logic        is_ch1;
  logic        capture_sel;
  logic [1:0]  edge_sel;
  logic        trig;
  logic        wr;
  logic [15:0] wdata;
  logic [15:0] ccr;
  logic        event_p;
  logic        toggle;
  modport core (output count, output tick, output running, output free_mode, output pwm_mode,
                output is_ch1, output capture_sel, output edge_sel, output trig, output wr,
                output wdata, input ccr, input event_p, input toggle);
  modport chan (input count, input tick, input running, input free_mode, input pwm_mode,
                input is_ch1, input capture_sel, input edge_sel, input trig, input wr,
                input wdata, output ccr, output event_p, output toggle);
endinterface : frt_chan_if

// File: hdl/frt_ahb.sv
/*
  AHB-Lite slave front end: single word transfers, zero wait states, always OKAY.
  Assumes the core answers reads combinationally from the address-phase address.
*/
`timescale 1ns/1ps
module frt_ahb
  import frt_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // AHB-Lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Core side
  frt_reg_if.slave         regs
);

  logic        wr_pend_q;
  logic [7:0]  waddr_q;
  logic        hreadyout_q;
  logic        hresp_q;
  logic [31:0] hrdata_q;

  // Address phase qualification; non-word sizes are ignored
  wire accept = hsel & hready & htrans[HTRANS_ACT_BIT] & (hsize == HSIZE_WORD);

  assign regs.wr    = wr_pend_q;
  assign regs.waddr = waddr_q;
  assign regs.wdata = hwdata;
  assign regs.rd    = accept & ~hwrite;
  assign regs.raddr = haddr[ADDR_W-1:0];

  // Read data sampled at the address phase so it stands through the data phase
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_pend_q   <= 1'b0;
      waddr_q     <= 8'h00;
      hreadyout_q <= 1'b1;
      hresp_q     <= HRESP_OKAY;
      hrdata_q    <= 32'h0000_0000;
    end else begin
      wr_pend_q   <= accept & hwrite;
      waddr_q     <= accept ? haddr[ADDR_W-1:0] : waddr_q;
      hreadyout_q <= 1'b1;
      hresp_q     <= HRESP_OKAY;
      hrdata_q    <= regs.rd ? regs.rdata : hrdata_q;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign hrdata    = hrdata_q;

endmodule : frt_ahb

// File: hdl/frt_chan.sv
/*
  One capture/compare channel: register, edge detector, compare and capture events.
  Assumes the core supplies the live count, a one-cycle count tick and the run state.
*/
`timescale 1ns/1ps
module frt_chan
  import frt_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Core link
  frt_chan_if.chan  bus
);

  logic        trig_q;
  logic        eq_q;
  logic [15:0] ccr_q;
  logic        event_q;
  logic        toggle_q;

  // Edge detection and selection
  wire rise     = bus.trig & ~trig_q;
  wire fall     = ~bus.trig & trig_q;
  wire edge_hit = ((bus.edge_sel == FRT_EDGE_RISE) & rise) | ((bus.edge_sel == FRT_EDGE_FALL) & fall) |
                  ((bus.edge_sel == FRT_EDGE_BOTH) & (rise | fall));
  wire do_capture = bus.running & bus.capture_sel & edge_hit;

  // Compare: late form fires on the count-up leaving D, early form on the count-up reaching D
  wire        eq        = (bus.count == ccr_q);
  wire [15:0] cnt_inc   = bus.count + 16'h0001;
  wire        early     = bus.pwm_mode & bus.is_ch1;
  wire        cmp_late  = bus.running & ~bus.capture_sel & ~early & bus.tick & eq;
  wire        cmp_early = bus.running & ~bus.capture_sel & early & bus.tick & (cnt_inc == ccr_q);
  wire cmp_hit   = cmp_late | cmp_early;

  // Capture beats a same-cycle software write; writes take effect at once
  wire [15:0] ccr_d = do_capture ? bus.count : (bus.wr ? bus.wdata : ccr_q);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trig_q   <= 1'b0;
      eq_q     <= 1'b0;
      ccr_q    <= CNT_ZERO;
      event_q  <= 1'b0;
      toggle_q <= 1'b0;
    end else begin
      trig_q   <= bus.trig;
      eq_q     <= eq;
      ccr_q    <= ccr_d;
      event_q  <= do_capture | cmp_hit;
      toggle_q <= cmp_hit & bus.free_mode;
    end
  end

  assign bus.ccr     = ccr_q;
  assign bus.event_p = event_q;
  assign bus.toggle  = toggle_q;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_cmp_next_tick: assert property (cmp_late |=> bus.event_p && (bus.toggle == $past(bus.free_mode)))
    else $error("compare event missing after count-up");
  a_pwm_early_irq: assert property (cmp_early |=> bus.event_p && bus.count == $past(ccr_q))
    else $error("early channel-1 match missing");
  a_pwm_no_late: assert property ((early && eq && eq_q && !do_capture) |=> !bus.event_p)
    else $error("channel-1 match repeated in PWM mode");
  a_capture_count: assert property (do_capture |=> ccr_q == $past(bus.count) && bus.event_p && !bus.toggle)
    else $error("capture did not store count");
  a_write_at_once: assert property ((bus.wr && !do_capture) |=> bus.ccr == $past(bus.wdata))
    else $error("compare write not applied");
  a_compare_holds: assert property ((!bus.capture_sel && !bus.wr) |=> ccr_q == $past(ccr_q))
    else $error("compare register changed without write");

  c_capture: cover property (do_capture);
  c_compare: cover property (cmp_late);

endmodule : frt_chan

// File: hdl/frt_timer.sv
/*
  Top of the free-running capture/compare timer: counter, control, option flag and register file.
  Assumes count_tick is a one-cycle pulse from an external prescaler and inputs are synchronous.
*/
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module frt_timer
  import frt_pkg::*;
#(
  parameter int CNT_BITS = frt_pkg::CNT_W
)(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Count clock and capture inputs
  input  wire logic        count_tick,
  input  wire logic        capture_trigger_input_0,
  input  wire logic        capture_trigger_input_1,
  // Timer outputs and event pulses
  output logic             timer_output_0,
  output logic             timer_output_1,
  output logic [1:0]       chan_match_capture_irq,
  output logic             counter_overflow_irq
);

  // Counter logic is built for exactly the documented width
  if (CNT_BITS != CNT_W) begin : g_bad_width
    $error("frt_timer supports only a 16-bit counter");
  end

  frt_reg_if  regs ();
  frt_chan_if ch_if [NCH] ();

  // Control and status state
  frt_state_t  state_q, state_d;
  logic        ce_q;
  logic [2:0]  mode_q;
  logic [1:0]  ccs_q;
  logic        ovf_q;
  logic [3:0]  edge_q;
  logic [15:0] cnt_q, cnt_d;
  logic        ovf_irq_q;
  logic        ovf_set;
  logic        out0_q;
  logic        out1_q;

  // Bus slave
  frt_ahb u_ahb (
    .clock     (clock),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .regs      (regs)
  );

  // Write decode
  wire wr_ctrl = regs.wr & frt_hit(regs.waddr, ADDR_CTRL);
  wire wr_opt  = regs.wr & frt_hit(regs.waddr, ADDR_OPT);
  wire wr_ccr0 = regs.wr & frt_hit(regs.waddr, ADDR_CCR0);
  wire wr_ccr1 = regs.wr & frt_hit(regs.waddr, ADDR_CCR1);
  wire wr_edge = regs.wr & frt_hit(regs.waddr, ADDR_EDGE);

  wire       w_ce   = regs.wdata[CTRL_CE_BIT];
  wire [2:0] w_mode = regs.wdata[CTRL_MODE_LSB +: MODE_W];

  // Enable edges; the start inversion belongs to free-running mode only
  wire ce_on      = wr_ctrl & w_ce & ~ce_q;
  wire ce_off     = wr_ctrl & ~w_ce;
  wire start_free = ce_on & (w_mode == MODE_FREE);
  wire running    = (state_q == FRT_RUN);
  wire free_mode  = (mode_q == MODE_FREE);

  // Overflow flag: only a written zero clears it, and a same-cycle wrap wins
  wire ovf_clr = wr_opt & ~regs.wdata[OPT_OVF_BIT];
  wire ovf_d   = ovf_set | (ovf_q & ~ovf_clr);

  // Counter sequencing: stopped counter sits at all ones, first tick lands on zero
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    ovf_set = 1'b0;
    case (state_q)
      FRT_STOP: begin
        if (ce_on) begin
          state_d = FRT_ARMED;
        end
      end
      FRT_ARMED: begin
        if (ce_off) begin
          state_d = FRT_STOP;
        end else if (count_tick) begin
          state_d = FRT_RUN;
          cnt_d   = CNT_ZERO;
        end
      end
      FRT_RUN: begin
        if (ce_off) begin
          state_d = FRT_STOP;
          cnt_d   = CNT_MAX;
        end else if (count_tick) begin
          cnt_d   = cnt_q + 16'h0001;
          ovf_set = (cnt_q == CNT_MAX);
        end
      end
      default: begin
        state_d = FRT_STOP;
        cnt_d   = CNT_MAX;
      end
    endcase
  end

  // Counter and control registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q   <= FRT_STOP;
      cnt_q     <= CNT_MAX;
      ce_q      <= 1'b0;
      mode_q    <= MODE_RST;
      ccs_q     <= CCS_RST;
      edge_q    <= EDGE_RST;
      ovf_q     <= 1'b0;
      ovf_irq_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      ce_q      <= wr_ctrl ? w_ce : ce_q;
      mode_q    <= wr_ctrl ? w_mode : mode_q;
      ccs_q     <= wr_opt ? regs.wdata[OPT_CCS_LSB +: NCH] : ccs_q;
      edge_q    <= wr_edge ? regs.wdata[EDGE_LSB +: NCH*EDGE_W] : edge_q;
      ovf_q     <= ovf_d;
      ovf_irq_q <= ovf_set;
    end
  end

  // Output inversion: start and each free-running compare event flip both pins
  wire flip = start_free ^ ch_if[0].toggle ^ ch_if[1].toggle;

  // Timer output pins; two same-cycle events cancel, matching two inversions
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out0_q <= 1'b0;
      out1_q <= 1'b0;
    end else begin
      out0_q <= out0_q ^ flip;
      out1_q <= out1_q ^ flip;
    end
  end

  // Channel instances
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign ch_if[i].count       = cnt_q;
    assign ch_if[i].tick        = count_tick;
    assign ch_if[i].running     = running;
    assign ch_if[i].free_mode   = free_mode;
    assign ch_if[i].pwm_mode    = (mode_q == MODE_PWM);
    assign ch_if[i].is_ch1      = (i == 1);
    assign ch_if[i].capture_sel = ccs_q[i];
    assign ch_if[i].edge_sel    = edge_q[i*EDGE_W +: EDGE_W];
    assign ch_if[i].wdata       = regs.wdata[CNT_W-1:0];
    frt_chan u_chan (
      .clock (clock),
      .rst_n (rst_n),
      .bus   (ch_if[i])
    );
  end

  assign ch_if[0].trig = capture_trigger_input_0;
  assign ch_if[1].trig = capture_trigger_input_1;
  assign ch_if[0].wr   = wr_ccr0;
  assign ch_if[1].wr   = wr_ccr1;

  // Counter read buffer shows zero while stopped, the live count while running
  wire [15:0] cnt_read = running ? cnt_q : CNT_ZERO;

  // Read words
  wire [31:0] ctrl_word = (32'(ce_q) << CTRL_CE_BIT) | (32'(mode_q) << CTRL_MODE_LSB);
  wire [31:0] opt_word  = (32'(ovf_q) << OPT_OVF_BIT) | (32'(ccs_q) << OPT_CCS_LSB);
  wire [31:0] stat_word = 32'({out1_q, out0_q}) << STAT_OUT_LSB;

  // Read select; unmapped addresses read as zero
  assign regs.rdata = ({32{frt_hit(regs.raddr, ADDR_CTRL)}} & ctrl_word)
                    | ({32{frt_hit(regs.raddr, ADDR_OPT)}}  & opt_word)
                    | ({32{frt_hit(regs.raddr, ADDR_CCR0)}} & 32'(ch_if[0].ccr))
                    | ({32{frt_hit(regs.raddr, ADDR_CCR1)}} & 32'(ch_if[1].ccr))
                    | ({32{frt_hit(regs.raddr, ADDR_CNT)}}  & 32'(cnt_read))
                    | ({32{frt_hit(regs.raddr, ADDR_EDGE)}} & 32'(edge_q))
                    | ({32{frt_hit(regs.raddr, ADDR_STAT)}} & stat_word);

  // Outputs straight from flops
  assign timer_output_0         = out0_q;
  assign timer_output_1         = out1_q;
  assign chan_match_capture_irq = {ch_if[1].event_p, ch_if[0].event_p};
  assign counter_overflow_irq   = ovf_irq_q;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_wrap_overflow: assert property ((running && count_tick && cnt_q == CNT_MAX && !ce_off)
                                    |=> counter_overflow_irq && cnt_q == CNT_ZERO && running)
    else $error("wrap did not overflow to zero");
  a_wrap_flag: assert property ((running && count_tick && cnt_q == CNT_MAX && !ce_off) |=> ovf_q)
    else $error("overflow flag not set on wrap");
  a_flag_sticky: assert property ((ovf_q && !ovf_clr) |=> ovf_q)
    else $error("overflow flag dropped without software clear");
  a_start_invert: assert property ((start_free && !ch_if[0].toggle && !ch_if[1].toggle)
                                   |=> timer_output_0 != $past(timer_output_0)
                                       && timer_output_1 != $past(timer_output_1))
    else $error("outputs not inverted at start");
  a_cmp_invert: assert property (((ch_if[0].toggle ^ ch_if[1].toggle) && !start_free)
                                 |=> timer_output_0 != $past(timer_output_0)
                                     && timer_output_1 != $past(timer_output_1))
    else $error("outputs not inverted on compare");
  a_free_start: assert property ((state_q == FRT_ARMED && count_tick && !ce_off)
                                 |=> running && cnt_q == CNT_ZERO ##1 !counter_overflow_irq)
    else $error("counting did not start at zero");
  a_cnt_readback: assert property ((regs.rd && frt_hit(regs.raddr, ADDR_CNT) && running)
                                   |=> hrdata == 32'($past(cnt_q)))
    else $error("counter read not live");

  c_overflow: cover property (counter_overflow_irq);
  c_start:    cover property (start_free);
  c_both_ch:  cover property (chan_match_capture_irq[0] ##[1:20] chan_match_capture_irq[1]);

endmodule : frt_timer

// File: sim/frt_pins.sv
/*
  Far-side model: drives both capture trigger inputs and watches the two timer outputs.
  Assumes one clock shared with the timer; trigger lines are plain levels with no pull.
*/
`timescale 1ns/1ps
module frt_pins (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Requests from the bench
  input  wire logic [1:0] fire,
  // Pins
  output logic [1:0]      trig,
  input  wire logic       out0,
  input  wire logic       out1,
  // Output activity
  output int              flips
);
  logic [1:0] last_q;

  // Trigger copies the request one edge later; flips counts every output change
  always @(posedge clock) begin
    if (!rst_n) begin
      trig   <= 2'h0;
      last_q <= 2'h0;
      flips  <= 0;
    end else begin
      trig   <= fire;
      last_q <= {out1, out0};
      flips  <= flips + int'(last_q[0] != out0) + int'(last_q[1] != out1);
    end
  end
endmodule : frt_pins

// File: sim/tb_frt_timer.sv
/*
  Self-checking bench: AHB-Lite master, event timestamps and scenarios measured from a wrap.
  Assumes count_tick is high every cycle, so the count equals cycles since the overflow pulse.
*/
`timescale 1ns/1ps
module tb_frt_timer;
  import frt_pkg::*;
  logic        clock, rst_n, hwrite, count_tick, hreadyout, hresp, out0, out1, ovf, prev1;
  logic [1:0]  htrans, irq, fire, trig;
  logic [31:0] haddr, hwdata, hrdata, rd, d;
  int          fail_count, checks_done, seed, cyc, t0, tc, ac, flips, lvl, inv, ov_n, ovp, tcp, cap0;
  int          ev_t[2], ev_n[2], seen[2];

  frt_timer u_frt_timer (.clock(clock), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .count_tick(count_tick), .capture_trigger_input_0(trig[0]),
    .capture_trigger_input_1(trig[1]), .timer_output_0(out0), .timer_output_1(out1),
    .chan_match_capture_irq(irq), .counter_overflow_irq(ovf));
  frt_pins u_frt_pins (.clock(clock), .rst_n(rst_n), .fire(fire), .trig(trig), .out0(out0),
    .out1(out1), .flips(flips));

  // Clock, 10 ns period
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Timestamps of wrap, trigger rise and channel events, in cycles
  always @(posedge clock) begin
    cyc   <= cyc + 1;
    prev1 <= trig[1];
    // Software-style overflow count kept apart from the hardware flag
    if (ovf === 1'b1) begin
      t0   <= cyc;
      ov_n <= ov_n + 1;
    end
    if (trig[1] === 1'b1 && prev1 === 1'b0) tc <= cyc;
    for (int i = 0; i < 2; i++) begin
      if (irq[i] === 1'b1) begin
        ev_t[i] <= cyc;
        ev_n[i] <= ev_n[i] + 1;
      end
    end
  end

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  // A used-up bound counts as a mismatch and ends the run
  task automatic lim(input int k, input int n);
    if (k >= n) begin
      fail_count++;
      wrap_up();
    end
  endtask : lim

  // One single word transfer; the bus answers when it samples hready high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] dw, output logic [31:0] r);
    int k;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    k = 0;
    do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 50);
    lim(k, 50);
    ac = cyc;
    htrans <= 2'h0;
    hwdata <= dw;
    k = 0;
    do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 50);
    lim(k, 50);
    r = hrdata;
  endtask : xfer

  // Waits for the next event of one channel, bounded
  task automatic wait_ev(input int ch);
    int k;
    k = 0;
    while (ev_n[ch] <= seen[ch] && k < 70000) begin
      @(posedge clock);
      #1;
      k++;
    end
    lim(k, 70000);
    seen[ch]++;
  endtask : wait_ev

  // Both outputs invert together on each free-running inversion
  task automatic outs;
    repeat (3) @(posedge clock);
    check("timer_output_0", out0, lvl[31:0]);  // Level
    check("timer_output_1", out1, lvl[31:0]);  // Level
  endtask : outs

  initial begin
    seed = 32'h0c37a754;
    {rst_n, hwrite, htrans, haddr, hwdata, fire, count_tick} = '0;
    {fail_count, checks_done, cyc, tc, lvl, inv, ev_t[0], ev_t[1], ev_n[0], ev_n[1], seen[0], seen[1]} = '0;
    {ov_n, ovp, tcp, cap0} = '0;
    t0 = -1;
    repeat (5) @(posedge clock);
    rst_n      <= 1'b1;
    count_tick <= 1'b1;
    xfer(1'b1, ADDR_OPT, 32'h30, rd);    // Both capture while first lap runs
    xfer(1'b1, ADDR_EDGE, 32'h0, rd);    // Unused inputs detect no edge
    xfer(1'b1, ADDR_CTRL, 32'h51, rd);   // Free-running, enabled
    lvl = 1;
    inv = 1;
    outs();                              // Start inverts
    for (int k = 0; t0 < 0; k++) begin
      @(posedge clock);
      #1;
      lim(k, 70000);
    end
    xfer(1'b0, ADDR_OPT, 32'h0, rd);
    check("overflow flag", rd, 32'h31);  // Flag set at wrap
    xfer(1'b1, ADDR_OPT, 32'h30, rd);    // Software clears after seeing one
    xfer(1'b0, ADDR_OPT, 32'h0, rd);
    check("cleared flag", rd, 32'h30);   // Cleared by write
    xfer(1'b0, ADDR_CNT, 32'h0, rd);
    check("counter", rd, ac - t0);       // Live count from zero after wrap
    // Channel 0 compare, then a rewrite while running
    xfer(1'b1, ADDR_OPT, 32'h20, rd);    // Ch0 compare, ch1 capture
    xfer(1'b1, ADDR_EDGE, 32'h4, rd);    // Ch1 rising only
    d = 32'h800 + ($random(seed) & 32'h7FF);
    for (int i = 0; i < 2; i++) begin
      xfer(1'b1, ADDR_CCR0, d, rd);
      wait_ev(0);
      check("ch0 match", ev_t[0] - t0, d + 1);  // Match at value plus one
      lvl ^= 1;
      inv++;
      outs();
      d = (d + 32'h40 + ($random(seed) & 32'hFF)) & 32'hFFFF;  // Next interval, wraps past FFFFH
    end
    // Capture on channel 1 at a random moment
    repeat ($random(seed) & 32'h3F) @(posedge clock);
    fire <= 2'h2;
    @(posedge clock);
    fire <= 2'h0;
    wait_ev(1);
    check("capture irq", ev_t[1] - tc, 32'h1);   // Irq one cycle after edge
    xfer(1'b0, ADDR_CCR1, 32'h0, rd);
    check("captured count", rd, tc - t0);        // Stored live count
    cap0 = rd;
    tcp  = tc;
    ovp  = ov_n;
    // Second capture: width from the difference of the two captures
    repeat (8 + ($random(seed) & 32'h3F)) @(posedge clock);
    fire <= 2'h2;
    @(posedge clock);
    fire <= 2'h0;
    wait_ev(1);
    xfer(1'b0, ADDR_CCR1, 32'h0, rd);
    check("pulse width", ((ov_n - ovp) << 16) + ((rd - cap0) & 32'hFFFF), tc - tcp);
    outs();
    // Channel 1 compare in free-running mode, then in PWM mode
    xfer(1'b1, ADDR_OPT, 32'h0, rd);
    for (int m = 0; m < 2; m++) begin
      d = cyc - t0 + 32'h100 + ($random(seed) & 32'hFF);
      xfer(1'b1, ADDR_CTRL, {25'h0, (m == 0) ? MODE_FREE : MODE_PWM, 4'h1}, rd);
      xfer(1'b1, ADDR_CCR1, d, rd);
      wait_ev(1);
      check("ch1 match", ev_t[1] - t0, (m == 0) ? d + 1 : d);  // Early only in PWM
      if (m == 0) begin
        lvl ^= 1;
        inv++;
      end
      outs();
    end
    check("output flips", flips, 2 * inv);       // Both pins per inversion
    wrap_up();
  end
endmodule : tb_frt_timer
